// ---- lcdc_params.svh ----
// Constants of the LCD command decoder: reset values, command codes, field positions, timing.
// Assumes inclusion by bare name from the package and modules of this block.
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH

`define LCDC_RST_DISP_EN 1'h0
`define LCDC_RST_FIRST_ROW 5'h00
`define LCDC_RST_PAGE 3'h7
`define LCDC_RST_COLUMN 7'h00
`define LCDC_RST_STATIC 1'h0
`define LCDC_RST_DUTY 1'h1
`define LCDC_RST_SEG_ORDER 1'h0
`define LCDC_RST_COND 4'h0

`define LCDC_CMD_DISP_MASK 8'hFE
`define LCDC_CMD_DISP_CODE 8'hAE
`define LCDC_CMD_ROW_MASK 8'hE0
`define LCDC_CMD_ROW_CODE 8'hC0
`define LCDC_CMD_PAGE_MASK 8'hFC
`define LCDC_CMD_PAGE_CODE 8'hB8
`define LCDC_CMD_SEG_MASK 8'hFE
`define LCDC_CMD_SEG_CODE 8'hA0
`define LCDC_CMD_STAT_MASK 8'hFE
`define LCDC_CMD_STAT_CODE 8'hA4
`define LCDC_CMD_DUTY_MASK 8'hFE
`define LCDC_CMD_DUTY_CODE 8'hA8
`define LCDC_CMD_COL_MASK 8'h80
`define LCDC_CMD_COL_CODE 8'h00

`define LCDC_COL_LAST 7'h4F
`define LCDC_COL_ONE 7'h01
`define LCDC_ROWS_HI 6'h20
`define LCDC_ROWS_LO 6'h10
`define LCDC_BUSY_BIT 7
`define LCDC_COND_DISP 0
`define LCDC_COND_STATIC 1
`define LCDC_COND_DUTY 2
`define LCDC_COND_SEG 3

`define LCDC_CLK_PERIOD_NS 4
`define LCDC_BUSY_NS 8
`define LCDC_BUSY_CYC ((`LCDC_BUSY_NS + `LCDC_CLK_PERIOD_NS - 1) / `LCDC_CLK_PERIOD_NS)

`endif

// ---- lcdc_pkg.sv ----
// Types shared by the LCD command decoder files.
// Assumes lcdc_params.svh is on the include path.
`default_nettype none
package lcdc_pkg;
  `include "lcdc_params.svh"
  typedef logic [7:0] lcdc_byte_t;
  typedef logic [4:0] lcdc_row_t;
  typedef enum logic [1:0] {
    LCDC_IDLE = 2'b00,
    LCDC_HOLD = 2'b01,
    LCDC_BUSY = 2'b10
  } lcdc_state_e;
endpackage : lcdc_pkg
`default_nettype wire

// ---- lcdc_row_map.sv ----
// Maps each common output to a memory row from the first-row pointer and duty.
// Assumes registered inputs from the decoder on the same clock.
`default_nettype none
module lcdc_row_map #(
  parameter int NCOM = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire lcdc_pkg::lcdc_row_t first_row_i,
  input wire logic duty_hi_i,
  input wire logic disp_en_i,
  output logic [NCOM*5-1:0] com_row_o,
  output logic [NCOM-1:0] com_idle_o
);
  import lcdc_pkg::*;
  // Only NCOM commons exist here; upper commons of a 32-row block are not shown
  for (genvar n = 0; n < NCOM; n++) begin : g_com
    wire [5:0] sum = {1'b0, first_row_i} + 6'(n);
    wire [4:0] wrapped = duty_hi_i ? sum[4:0] : {1'b0, sum[3:0]} ^ {first_row_i[4], 4'h0};
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        com_row_o[n*5 +: 5] <= 5'h00;
        com_idle_o[n] <= 1'b1;
      end else begin
        com_row_o[n*5 +: 5] <= wrapped;
        com_idle_o[n] <= !disp_en_i;
      end
    end
  end
endmodule : lcdc_row_map
`default_nettype wire

// ---- lcdc_decoder.sv ----
// Command decoder and control registers of a dot-matrix LCD controller half.
// Assumes an asynchronous 8-bit host bus; all control pins are synchronised here.
`default_nettype none
// Overview of operation
// - Reset clears display enable, panel dark.
// - Reset clears first-row pointer to zero.
// - Reset sets page pointer to all ones.
// - Reset clears seven-bit column pointer.
// - Reset clears static drive bit.
// - Reset sets duty bit to one, 1/32 duty.
// - Reset selects normal segment ordering.
// - Reset clears condition flags.
// - Display off forces all commons to idle level.
// - Command write: half select high, command/data select low, enable high, read/write low.
// - AF turns display on, AE turns it off.
// - First-row pointer picks memory row shown on common zero.
// - Scanned block is 32 rows at high duty, 16 at low.
// - Row addressing wraps modulo block length.
// - Only the lower sixteen commons exist on this device.
// - C0 to DF load the first-row pointer.
// - Each half answers only to its own active-high select.
// - Data lines driven only during reads, released otherwise; here status reads drive them, data reads do not.
// - Status read shows busy on the top data line.
// - B8 to BB load the page pointer.
// - Column pointer advances after each memory access, wrapping after 79.
// - A0/A1 load segment ordering bit.
// - A8/A9 load duty bit.
module lcdc_decoder #(
  parameter int NCOM = 16,
  parameter bit RIGHT_HALF = 1'b0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic left_half_select_i,
  input wire logic right_half_select_i,
  input wire logic cmd_data_sel_i,
  input wire logic read_write_i,
  input wire logic access_strobe_pin_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic display_enable_o,
  output lcdc_pkg::lcdc_row_t first_row_pointer_o,
  output logic [2:0] page_pointer_o,
  output logic [6:0] column_pointer_o,
  output logic static_drive_enable_o,
  output logic multiplex_ratio_select_o,
  output logic segment_order_select_o,
  output logic [3:0] condition_flags_o,
  output logic [NCOM*5-1:0] com_row_o,
  output logic [NCOM-1:0] com_idle_o
);
  import lcdc_pkg::*;

  // Two-stage synchronisers; the first stage feeds only the second
  logic [11:0] sync_a;
  logic [11:0] sync_b;
  logic strobe_d;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_a <= 12'h000;
      sync_b <= 12'h000;
      strobe_d <= 1'b0;
    end else begin
      sync_a <= {left_half_select_i, right_half_select_i, cmd_data_sel_i, read_write_i,
                 access_strobe_pin_i, data_i[6:0]} ^ 12'h000;
      sync_b <= sync_a;
      strobe_d <= sync_b[7];
    end
  end
  // Data bit 7 travels in its own pair to keep the bundle narrow
  logic d7_a;
  logic d7_b;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d7_a <= 1'b0;
      d7_b <= 1'b0;
    end else begin
      d7_a <= data_i[7];
      d7_b <= d7_a;
    end
  end

  wire sel_s = RIGHT_HALF ? sync_b[10] : sync_b[11];
  wire cd_s = sync_b[9];
  wire rw_s = sync_b[8];
  wire en_s = sync_b[7];
  wire [7:0] byte_s = {d7_b, sync_b[6:0]};
  // Latch on the falling edge of enable so data is settled for the whole pulse
  wire en_fall = strobe_d && !en_s;
  wire cmd_wr = en_fall && sel_s && !cd_s && !rw_s;
  wire mem_acc = en_fall && sel_s && cd_s;
  wire rd_act = en_s && sel_s && rw_s;

  wire hit_disp = (byte_s & `LCDC_CMD_DISP_MASK) == `LCDC_CMD_DISP_CODE;
  wire hit_row = (byte_s & `LCDC_CMD_ROW_MASK) == `LCDC_CMD_ROW_CODE;
  wire hit_page = (byte_s & `LCDC_CMD_PAGE_MASK) == `LCDC_CMD_PAGE_CODE;
  wire hit_seg = (byte_s & `LCDC_CMD_SEG_MASK) == `LCDC_CMD_SEG_CODE;
  wire hit_stat = (byte_s & `LCDC_CMD_STAT_MASK) == `LCDC_CMD_STAT_CODE;
  wire hit_duty = (byte_s & `LCDC_CMD_DUTY_MASK) == `LCDC_CMD_DUTY_CODE;
  wire hit_col = (byte_s & `LCDC_CMD_COL_MASK) == `LCDC_CMD_COL_CODE;
  wire [6:0] next_column = (column_pointer_o == `LCDC_COL_LAST) ? `LCDC_RST_COLUMN
                           : column_pointer_o + `LCDC_COL_ONE;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      display_enable_o <= `LCDC_RST_DISP_EN;
      first_row_pointer_o <= `LCDC_RST_FIRST_ROW;
      page_pointer_o <= `LCDC_RST_PAGE;
      column_pointer_o <= `LCDC_RST_COLUMN;
      static_drive_enable_o <= `LCDC_RST_STATIC;
      multiplex_ratio_select_o <= `LCDC_RST_DUTY;
      segment_order_select_o <= `LCDC_RST_SEG_ORDER;
    end else begin
      // Unmatched command bytes fall through every branch and change nothing
      if (cmd_wr && hit_disp) display_enable_o <= byte_s[0];
      if (cmd_wr && hit_row) first_row_pointer_o <= byte_s[4:0];
      if (cmd_wr && hit_page) page_pointer_o <= {1'b0, byte_s[1:0]};
      if (cmd_wr && hit_seg) segment_order_select_o <= byte_s[0];
      if (cmd_wr && hit_stat) static_drive_enable_o <= byte_s[0];
      if (cmd_wr && hit_duty) multiplex_ratio_select_o <= byte_s[0];
      if (cmd_wr && hit_col) column_pointer_o <= byte_s[6:0];
      else if (mem_acc) column_pointer_o <= next_column;
    end
  end

  // Busy is held a short fixed time after each write or access accepted while idle; one accepted while busy does not restart it
  lcdc_state_e state;
  lcdc_state_e next_state;
  logic [3:0] busy_cnt;
  wire accepted = cmd_wr || mem_acc;
  always_comb begin
    next_state = state;
    case (state)
      LCDC_IDLE: if (accepted) next_state = LCDC_BUSY;
      LCDC_BUSY: if (busy_cnt == 4'(`LCDC_BUSY_CYC - 1)) next_state = LCDC_IDLE;
      LCDC_HOLD: next_state = LCDC_IDLE;
      default: next_state = LCDC_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= LCDC_IDLE;
      busy_cnt <= 4'h0;
    end else begin
      state <= next_state;
      busy_cnt <= (state == LCDC_BUSY) ? busy_cnt + 4'h1 : 4'h0;
    end
  end

  wire [3:0] next_cond = {segment_order_select_o, multiplex_ratio_select_o,
                          static_drive_enable_o, display_enable_o};
  wire [7:0] next_read = {state == LCDC_BUSY, 3'h0, condition_flags_o};
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      condition_flags_o <= `LCDC_RST_COND;
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
    end else begin
      condition_flags_o <= next_cond;
      data_o <= next_read;
      data_oe_o <= rd_act && !cd_s;
    end
  end

  lcdc_row_map #(
    .NCOM(NCOM)
  ) u_row_map (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .first_row_i(first_row_pointer_o),
    .duty_hi_i(multiplex_ratio_select_o),
    .disp_en_i(display_enable_o),
    .com_row_o(com_row_o),
    .com_idle_o(com_idle_o)
  );

  reset_vals_a: assert property (@(posedge clk_i) $rose(rstn_i) |->
    page_pointer_o == 3'h7 && multiplex_ratio_select_o && !display_enable_o)
    else $error("reset values wrong");
  disp_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_wr && hit_disp |=> display_enable_o == $past(byte_s[0]))
    else $error("display enable not loaded");
  row_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_wr && hit_row |=> first_row_pointer_o == $past(byte_s[4:0]))
    else $error("first row not loaded");
  col_wrap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mem_acc && column_pointer_o == 7'h4F |=> column_pointer_o == 7'h00)
    else $error("column did not wrap");
  unsel_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !sel_s |=> !data_oe_o)
    else $error("drive while unselected");
  write_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !rw_s |=> !data_oe_o)
    else $error("drive during write");
  busy_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    accepted && state == LCDC_IDLE |=> ##1 data_o[7])
    else $error("busy not shown");
  idle_com_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !display_enable_o |=> &com_idle_o)
    else $error("commons driven when off");
  duty_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    cmd_wr && hit_duty |=> multiplex_ratio_select_o == $past(byte_s[0]))
    else $error("duty not loaded");
  cover_disp_on: cover property (@(posedge clk_i) cmd_wr && byte_s == 8'hAF);
  cover_row_set: cover property (@(posedge clk_i) cmd_wr && hit_row);
  cover_col_wrap: cover property (@(posedge clk_i) mem_acc && column_pointer_o == 7'h4F);
endmodule : lcdc_decoder
`default_nettype wire

// ---- lcdc_host_model.sv ----
// Host processor model: one access at a time on the command bus.
// Assumes one clock; bus pins change just after rising edges.
`default_nettype none
module lcdc_host_model (
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  input wire logic bus_oe_i,
  output logic left_o,
  output logic right_o,
  output logic cd_o,
  output logic rw_o,
  output logic strobe_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {left_o, right_o, cd_o, rw_o, strobe_o} = 5'h0;
    data_o = 8'h00;
  end
  // Bus held 5 cycles past the strobe fall: the device samples through a
  // two-flop synchroniser, so a shorter hold would race it
  task automatic access(input logic l, r, c, w, input logic [7:0] v,
      output logic [7:0] got, output logic oe);
    @(posedge clk_i);
    left_o <= l;
    right_o <= r;
    cd_o <= c;
    rw_o <= w;
    data_o <= v;
    @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    got = bus_i;
    oe = bus_oe_i;
    strobe_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    {left_o, right_o} <= 2'b00;
    // A released line shows the inverse, never a stale copy
    data_o <= ~v;
    repeat (4) @(posedge clk_i);
  endtask : access
endmodule : lcdc_host_model
`default_nettype wire

// ---- lcd_command_register_decoder_test.sv ----
// Self-checking bench for the left half of the LCD command decoder.
// Assumes the host model drives every bus input of the decoder.
`default_nettype none
module lcd_command_register_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdc_pkg::*;
  logic clk_i, rstn_i, left, right, cd, rw, strobe, oe, en, stat, duty, seg, got_oe;
  logic [7:0] hdata, dout, got;
  lcdc_row_t row;
  logic [2:0] page;
  logic [6:0] col;
  logic [3:0] flags;
  logic [79:0] com_row;
  logic [15:0] com_idle;
  int fails = 0;
  int num_checks = 0;
  lcdc_host_model i_lcdc_host_model (.clk_i(clk_i), .bus_i(dout), .bus_oe_i(oe),
    .left_o(left), .right_o(right), .cd_o(cd), .rw_o(rw), .strobe_o(strobe), .data_o(hdata));
  lcdc_decoder i_lcdc_decoder (.clk_i(clk_i), .rstn_i(rstn_i), .left_half_select_i(left),
    .right_half_select_i(right), .cmd_data_sel_i(cd), .read_write_i(rw),
    .access_strobe_pin_i(strobe), .data_i(hdata), .data_o(dout), .data_oe_o(oe),
    .display_enable_o(en), .first_row_pointer_o(row), .page_pointer_o(page),
    .column_pointer_o(col), .static_drive_enable_o(stat), .multiplex_ratio_select_o(duty),
    .segment_order_select_o(seg), .condition_flags_o(flags), .com_row_o(com_row),
    .com_idle_o(com_idle));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic acc(input logic l, r, c, w, input logic [7:0] v);
    i_lcdc_host_model.access(l, r, c, w, v, got, got_oe);
  endtask : acc
  task automatic cmd(input logic [7:0] v);
    acc(1'b1, 1'b0, 1'b0, 1'b0, v);
  endtask : cmd
  task automatic t_reset();
    check("enable", 16'h0000, 16'(en));
    check("start", 16'h0000, 16'(row));
    check("page", 16'h0007, 16'(page));
    check("column", 16'h0000, 16'(col));
    check("static", 16'h0000, 16'(stat));
    check("duty", 16'h0001, 16'(duty));
    check("order", 16'h0000, 16'(seg));
    // Flags follow the live registers, so the duty bit shows once reset is gone
    check("flags run", 16'h0004, 16'(flags));
    check("idle", 16'hFFFF, com_idle);
    check("drive", 16'h0000, 16'(oe));
  endtask : t_reset
  task automatic t_display();
    cmd(8'hAF);
    check("enable on", 16'h0001, 16'(en));
    check("idle on", 16'h0000, com_idle);
    check("flags on", 16'h0005, 16'(flags));
    cmd(8'hAE);
    check("enable off", 16'h0000, 16'(en));
    check("idle off", 16'hFFFF, com_idle);
  endtask : t_display
  task automatic t_rows();
    cmd(8'hAF);
    cmd(8'hDF);
    check("start", 16'h001F, 16'(row));
    for (int n = 0; n < 16; n++) begin
      check("row hi", 16'((31 + n) % 32), 16'(com_row[n*5+:5]));
    end
    cmd(8'hA8);
    check("duty lo", 16'h0000, 16'(duty));
    for (int n = 0; n < 16; n++) begin
      check("row lo", 16'(16 + (15 + n) % 16), 16'(com_row[n*5+:5]));
    end
    cmd(8'hA9);
    check("duty hi", 16'h0001, 16'(duty));
    cmd(8'hAE);
  endtask : t_rows
  task automatic t_page();
    for (int p = 0; p < 4; p++) begin
      cmd(8'hB8 + 8'(p));
      check("page", 16'(p), 16'(page));
    end
  endtask : t_page
  task automatic t_column();
    cmd(8'h4F);
    check("column", 16'h004F, 16'(col));
    acc(1'b1, 1'b0, 1'b1, 1'b0, 8'h55);
    check("col wrap", 16'h0000, 16'(col));
    acc(1'b1, 1'b0, 1'b1, 1'b1, 8'h00);
    check("col step", 16'h0001, 16'(col));
  endtask : t_column
  task automatic t_modes();
    cmd(8'hA1);
    cmd(8'hA5);
    check("order", 16'h0001, 16'(seg));
    check("flags", 16'h000E, 16'(flags));
    cmd(8'hA0);
    cmd(8'hA4);
    check("flags", 16'h0004, 16'(flags));
  endtask : t_modes
  task automatic t_select();
    acc(1'b0, 1'b1, 1'b0, 1'b0, 8'hAF);
    check("other half", 16'h0000, 16'(en));
    acc(1'b0, 1'b1, 1'b0, 1'b1, 8'h00);
    check("other drive", 16'h0000, 16'(got_oe));
    cmd(8'hE0);
    check("unknown", 16'h0004, 16'(flags));
    check("unk page", 16'h0003, 16'(page));
    check("unk start", 16'h001F, 16'(row));
  endtask : t_select
  task automatic t_status();
    acc(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
    check("read drive", 16'h0001, 16'(got_oe));
    check("status", 16'h0004, 16'(got));
    check("released", 16'h0000, 16'(oe));
  endtask : t_status
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // About 380 cycles expected; the margin covers slow handshakes
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    give_verdict();
  end
  initial begin
    rstn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    check("flags", 16'h0000, 16'(flags));
    @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    t_reset();
    t_display();
    t_rows();
    t_page();
    t_column();
    t_modes();
    t_select();
    t_status();
    give_verdict();
  end
endmodule : lcd_command_register_decoder_test
`default_nettype wire
